//--- src/cbsrl_defines.svh
// constants of the bus strobe, ready and lock block
`ifndef CBSRL_DEFINES_SVH
`define CBSRL_DEFINES_SVH

// ====================================================================
// strap sampling
`define CBSRL_STRAP_WAIT      2'h3
`define CBSRL_STRAP_CNT_W     2

// ====================================================================
// pin levels
`define CBSRL_PIN_HIGH        1'h1
`define CBSRL_PIN_LOW         1'h0
`define CBSRL_QS_STRAP_LEVEL  1'h0

// ====================================================================
// reset values of the sync stages
`define CBSRL_SYNC_RST        1'h0

`endif

//--- src/cbsrl_pkg.sv
// types shared by the bus strobe, ready and lock block
package cbsrl_pkg;

  // ==================================================================
  // bus cycle kinds asked for by the sequencer
  typedef enum logic [1:0] {
    CBSRL_KIND_READ  = 2'h0,
    CBSRL_KIND_WRITE = 2'h1,
    CBSRL_KIND_FETCH = 2'h2,
    CBSRL_KIND_IDLE  = 2'h3
  } cbsrl_kind_t;

  // ==================================================================
  // clock states of one bus cycle
  typedef enum logic [2:0] {
    CBSRL_TI = 3'h0,
    CBSRL_T1 = 3'h1,
    CBSRL_T2 = 3'h2,
    CBSRL_T3 = 3'h3,
    CBSRL_TW = 3'h4,
    CBSRL_T4 = 3'h5
  } cbsrl_state_t;

  // ==================================================================
  // request from the sequencer
  typedef struct packed {
    logic        valid;
    cbsrl_kind_t kind;
  } cbsrl_req_t;

  // ==================================================================
  // status back to the sequencer
  typedef struct packed {
    cbsrl_state_t t_state;
    logic         waiting;
    logic         locked;
    logic         qs_mode;
    logic         strap_done;
  } cbsrl_stat_t;

endpackage : cbsrl_pkg

//--- src/cbsrl_sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`include "cbsrl_defines.svh"

module cbsrl_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  if (WIDTH < 1) begin : g_chk
    $error("cbsrl_sync2: WIDTH must be at least 1");
  end

  // ==================================================================
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{`CBSRL_SYNC_RST}};
      q_reg    <= {WIDTH{`CBSRL_SYNC_RST}};
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : cbsrl_sync2

//--- src/cbsrl_pin_drv.sv
// output pin that drives high in reset and for one clock after release, then floats unless drive_req is set
`timescale 1ns/1ps
`include "cbsrl_defines.svh"

module cbsrl_pin_drv (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic drive_req,
  input  wire logic drive_val,
  output logic      pin_out,
  output logic      pin_oe
);

  logic rst_drive_reg;
  logic rst_drive_next;

  // ==================================================================
  // high while reset holds, one clock beyond release, then let go
  always_comb begin
    rst_drive_next = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_drive_reg <= 1'b1;
    end else begin
      rst_drive_reg <= rst_drive_next;
    end
  end

  assign pin_oe  = rst_drive_reg | drive_req;
  assign pin_out = rst_drive_reg ? `CBSRL_PIN_HIGH : drive_val;

endmodule : cbsrl_pin_drv

//--- src/cbsrl_top.sv
// bus cycle strobe, ready and lock control of the local bus
`timescale 1ns/1ps
`include "cbsrl_defines.svh"

// How it works
// - read strobe low in T2, T3, waits
// - strobe falls only after address floats
// - float strobe in hold; reset drive once
// - weak pull-up keeps undriven strobe high
// - strobe pin strap selects queue status
// - queue mode: latch/store pins carry code
// - async ready rising edge synchronised first
// - cycle ends only on a ready input
// - ready held high means no waits
// - sync ready used directly, no resolution
// - others keep off bus while locked
// - lock asserts at first data cycle
// - lock holds until instruction completes
// - no prefetch cycles while locked
// - lock driven high in reset, then floats
module cbsrl_top
  import cbsrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire cbsrl_req_t  cyc_req,
  output logic             cyc_req_ready,
  output logic             cyc_done,
  output cbsrl_stat_t      stat,
  input  wire logic        hold_float,
  input  wire logic        lock_prefix,
  input  wire logic        instr_done,
  input  wire logic [1:0]  queue_code,
  input  wire logic        async_ready_in,
  input  wire logic        sync_ready_in,
  output logic             addr_oe,
  input  wire logic        read_strobe_n_in,
  output logic             read_strobe_n_out,
  output logic             read_strobe_n_oe,
  output logic             read_strobe_pullup_en,
  output logic             address_latch_strobe,
  output logic             store_strobe_n,
  output logic             lock_n_out,
  output logic             lock_n_oe
);

  // ==================================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==================================================================
  // pin synchronisers
  logic async_ready_sync;
  logic strap_sync;

  // both edges pass the stages; the far side keeps the fall clean
  cbsrl_sync2 #(.WIDTH(1)) u_ready_sync (
    .clk   (clk),
    .rst_n (rst_n_reg),
    .d     (async_ready_in),
    .q     (async_ready_sync)
  );

  cbsrl_sync2 #(.WIDTH(1)) u_strap_sync (
    .clk   (clk),
    .rst_n (rst_n_reg),
    .d     (read_strobe_n_in),
    .q     (strap_sync)
  );

  // ==================================================================
  // strap capture after the strobe pin has floated
  logic [`CBSRL_STRAP_CNT_W-1:0] strap_cnt_reg;
  logic [`CBSRL_STRAP_CNT_W-1:0] strap_cnt_next;
  logic                          strap_done_reg;
  logic                          strap_done_next;
  logic                          qs_mode_reg;
  logic                          qs_mode_next;

  always_comb begin
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    qs_mode_next    = qs_mode_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == `CBSRL_STRAP_WAIT) begin
        strap_done_next = 1'b1;
        qs_mode_next    = (strap_sync == `CBSRL_QS_STRAP_LEVEL);
      end else begin
        strap_cnt_next = strap_cnt_reg + {{(`CBSRL_STRAP_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      strap_cnt_reg  <= '0;
      strap_done_reg <= 1'b0;
      qs_mode_reg    <= 1'b0;
    end else begin
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      qs_mode_reg    <= qs_mode_next;
    end
  end

  // ==================================================================
  // lock tracking
  logic lock_pend_reg;
  logic lock_pend_next;
  logic lock_act_reg;
  logic lock_act_next;
  logic start_cyc;
  logic data_kind;

  assign data_kind = (cyc_req.kind == CBSRL_KIND_READ) ||
                     (cyc_req.kind == CBSRL_KIND_WRITE);

  always_comb begin
    lock_pend_next = lock_pend_reg;
    lock_act_next  = lock_act_reg;
    if (lock_act_reg && instr_done) begin
      lock_act_next = 1'b0;
    end
    if (lock_pend_reg && start_cyc && data_kind) begin
      lock_pend_next = 1'b0;
      lock_act_next  = 1'b1;
    end
    if (lock_prefix) begin
      lock_pend_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lock_pend_reg <= 1'b0;
      lock_act_reg  <= 1'b0;
    end else begin
      lock_pend_reg <= lock_pend_next;
      lock_act_reg  <= lock_act_next;
    end
  end

  // ==================================================================
  // clock state sequencer
  cbsrl_state_t state_reg;
  cbsrl_state_t state_next;
  cbsrl_kind_t  kind_reg;
  cbsrl_kind_t  kind_next;
  logic         ready_ok;
  logic         fetch_blocked;

  // sync ready skips the two flip-flop synchroniser of the async path
  assign ready_ok      = async_ready_sync | sync_ready_in;
  assign fetch_blocked = lock_act_reg && (cyc_req.kind == CBSRL_KIND_FETCH);

  // a new cycle is taken only from idle or at the end of T4
  assign cyc_req_ready = strap_done_reg && !hold_float && !fetch_blocked &&
                         ((state_reg == CBSRL_TI) || (state_reg == CBSRL_T4));
  assign start_cyc     = cyc_req_ready && cyc_req.valid &&
                         (cyc_req.kind != CBSRL_KIND_IDLE);

  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    unique case (state_reg)
      CBSRL_TI, CBSRL_T4: begin
        if (start_cyc) begin
          state_next = CBSRL_T1;
          kind_next  = cyc_req.kind;
        end else begin
          state_next = CBSRL_TI;
        end
      end
      CBSRL_T1: begin
        state_next = CBSRL_T2;
      end
      CBSRL_T2: begin
        state_next = CBSRL_T3;
      end
      CBSRL_T3, CBSRL_TW: begin
        // readiness looked at once per clock; held high gives no waits
        state_next = ready_ok ? CBSRL_T4 : CBSRL_TW;
      end
      default: begin
        state_next = CBSRL_TI;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= CBSRL_TI;
      kind_reg  <= CBSRL_KIND_IDLE;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
    end
  end

  assign cyc_done = (state_reg == CBSRL_T4);

  // ==================================================================
  // address drivers and strobes
  logic addr_oe_reg;
  logic addr_oe_next;
  logic rd_low_reg;
  logic rd_low_next;
  logic ale_reg;
  logic ale_next;
  logic wr_low_reg;
  logic wr_low_next;
  logic in_data_phase;

  assign in_data_phase = (state_next == CBSRL_T2) || (state_next == CBSRL_T3) ||
                         (state_next == CBSRL_TW);

  always_comb begin
    // address floats from T2 of a read onward
    addr_oe_next = (state_next == CBSRL_T1) ||
                   (in_data_phase && (kind_next == CBSRL_KIND_WRITE));
    // queue mode: the queue code goes out through the strobe flops
    ale_next     = qs_mode_reg ? queue_code[0] : (state_next == CBSRL_T1);
    wr_low_next  = qs_mode_reg ? !queue_code[1] :
                   (in_data_phase && (kind_next == CBSRL_KIND_WRITE));
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_oe_reg <= 1'b0;
      ale_reg     <= 1'b0;
      wr_low_reg  <= 1'b0;
    end else begin
      addr_oe_reg <= addr_oe_next;
      ale_reg     <= ale_next;
      wr_low_reg  <= wr_low_next;
    end
  end

  // falls half a clock into T2, after the address has let go
  always_comb begin
    rd_low_next = !addr_oe_reg && (kind_reg != CBSRL_KIND_WRITE) &&
                  (kind_reg != CBSRL_KIND_IDLE) &&
                  ((state_reg == CBSRL_T2) || (state_reg == CBSRL_T3) ||
                   (state_reg == CBSRL_TW));
  end

  always_ff @(negedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_low_reg <= 1'b0;
    end else begin
      rd_low_reg <= rd_low_next;
    end
  end

  assign addr_oe = addr_oe_reg;

  // queue mode reuses the latch and store pins for the queue code
  assign address_latch_strobe = ale_reg;
  assign store_strobe_n       = !wr_low_reg;

  // ==================================================================
  // three-state pins
  logic rd_drive;

  // strap pin is never driven in queue mode; floats for another master
  assign rd_drive = strap_done_reg && !qs_mode_reg && !hold_float;

  cbsrl_pin_drv u_read_pin (
    .clk       (clk),
    .rst_n     (rst_n_reg),
    .drive_req (rd_drive),
    .drive_val (!rd_low_reg),
    .pin_out   (read_strobe_n_out),
    .pin_oe    (read_strobe_n_oe)
  );

  assign read_strobe_pullup_en = !read_strobe_n_oe;

  // low lock tells other masters to stay off the bus
  cbsrl_pin_drv u_lock_pin (
    .clk       (clk),
    .rst_n     (rst_n_reg),
    .drive_req (lock_act_reg),
    .drive_val (!lock_act_reg),
    .pin_out   (lock_n_out),
    .pin_oe    (lock_n_oe)
  );

  // ==================================================================
  // status
  assign stat = '{t_state:    state_reg,
                  waiting:    (state_reg == CBSRL_TW),
                  locked:     lock_act_reg,
                  qs_mode:    qs_mode_reg,
                  strap_done: strap_done_reg};

endmodule : cbsrl_top

//--- verification/cbsrl_top_properties.sv
// checker of the bus strobe, ready and lock block
`timescale 1ns/1ps
module cbsrl_chk
  import cbsrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire cbsrl_req_t  cyc_req,
  input wire logic        cyc_req_ready,
  input wire logic        cyc_done,
  input wire cbsrl_stat_t stat,
  input wire logic        hold_float,
  input wire logic        async_ready_in,
  input wire logic        sync_ready_in,
  input wire logic        addr_oe,
  input wire logic        read_strobe_n_out,
  input wire logic        read_strobe_n_oe,
  input wire logic        read_strobe_pullup_en,
  input wire logic        lock_n_out,
  input wire logic        lock_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==================================================================
  // strobe window
  rd_strobe_win_a: assert property (read_strobe_n_oe && !read_strobe_n_out
    |-> stat.t_state inside {CBSRL_T2, CBSRL_T3, CBSRL_TW}) else $error("strobe outside");
  rd_addr_float_a: assert property (read_strobe_n_oe && !read_strobe_n_out
    |-> !addr_oe) else $error("strobe low with address driven");
  rd_hold_float_a: assert property (hold_float && $past(hold_float)
    |-> !read_strobe_n_oe) else $error("strobe driven in hold");
  pullup_on_a: assert property (read_strobe_pullup_en == !read_strobe_n_oe)
    else $error("pull-up wrong");
  // ==================================================================
  // reset drive, then float
  rst_drive_a: assert property ($rose(rstn) |-> read_strobe_n_oe && read_strobe_n_out
    && lock_n_oe && lock_n_out) else $error("pins not driven high in reset");
  rst_float_a: assert property ($rose(rstn) |-> ##3 !lock_n_oe && !read_strobe_n_oe)
    else $error("pins not floated after reset");
  // ==================================================================
  // lock and ready
  lock_pin_a: assert property (stat.locked |-> ##[0:1] (lock_n_oe && !lock_n_out))
    else $error("lock pin not low");
  no_fetch_lock_a: assert property (stat.locked && cyc_req.valid
    && cyc_req.kind == CBSRL_KIND_FETCH |-> !cyc_req_ready) else $error("fetch while locked");
  wait_noready_a: assert property (stat.t_state inside {CBSRL_T3, CBSRL_TW}
    && !sync_ready_in && !async_ready_in && !$past(async_ready_in)
    && !$past(async_ready_in, 2) |=> stat.t_state == CBSRL_TW) else $error("no wait state");
  sync_end_a: assert property (stat.t_state inside {CBSRL_T3, CBSRL_TW} && sync_ready_in
    |=> stat.t_state == CBSRL_T4 && cyc_done) else $error("sync ready not used at once");
  done_pulse_a: assert property (cyc_done |-> stat.t_state == CBSRL_T4 ##1 !cyc_done)
    else $error("done not a T4 pulse");
endmodule : cbsrl_chk

bind cbsrl_top cbsrl_chk u_chk (.clk(clk), .rstn(rstn), .cyc_req(cyc_req),
  .cyc_req_ready(cyc_req_ready), .cyc_done(cyc_done), .stat(stat), .hold_float(hold_float),
  .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in), .addr_oe(addr_oe),
  .read_strobe_n_out(read_strobe_n_out), .read_strobe_n_oe(read_strobe_n_oe),
  .read_strobe_pullup_en(read_strobe_pullup_en), .lock_n_out(lock_n_out),
  .lock_n_oe(lock_n_oe));

//--- verification/cbsrl_mem_model.sv
// memory and I/O ready logic on the far side of the bus
`timescale 1ns/1ps
module cbsrl_mem_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       address_latch_strobe,
  input  wire logic       cyc_done,
  input  wire logic [3:0] waits,
  input  wire logic [1:0] mode,
  output logic            async_ready_in,
  output logic            sync_ready_in
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  // ==================================================================
  // wait counter, loaded at the address latch strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= 4'h0;
      busy_reg <= 1'h0;
    end else if (address_latch_strobe) begin
      cnt_reg  <= waits + 4'h1;
      busy_reg <= 1'h1;
    end else begin
      if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
      if (cyc_done)
        busy_reg <= 1'h0;
    end
  end
  // lines move only after clock edges, so every fall is synchronous
  assign sync_ready_in  = busy_reg && cnt_reg == 4'h0 && mode == 2'h0;
  assign async_ready_in = (mode == 2'h2) || (busy_reg && cnt_reg == 4'h0 && mode == 2'h1);
endmodule : cbsrl_mem_model

//--- verification/tb_top.sv
// self-checking testbench of the bus strobe, ready and lock block
`timescale 1ns/1ps
module tb_top
  import cbsrl_pkg::*;
;
  logic        clk, rstn, cyc_req_ready, cyc_done, hold_float, lock_prefix, instr_done;
  cbsrl_req_t  cyc_req;
  cbsrl_stat_t stat;
  logic [1:0]  queue_code, pm_mode;
  logic [3:0]  pm_waits;
  logic        async_ready_in, sync_ready_in, addr_oe, read_strobe_n_in, read_strobe_n_out;
  logic        read_strobe_n_oe, read_strobe_pullup_en, address_latch_strobe, store_strobe_n;
  logic        lock_n_out, lock_n_oe, strap_gnd;
  int          fails, comparisons;

  cbsrl_top uut (.clk, .rstn, .cyc_req, .cyc_req_ready, .cyc_done, .stat, .hold_float,
    .lock_prefix, .instr_done, .queue_code, .async_ready_in, .sync_ready_in, .addr_oe,
    .read_strobe_n_in, .read_strobe_n_out, .read_strobe_n_oe, .read_strobe_pullup_en,
    .address_latch_strobe, .store_strobe_n, .lock_n_out, .lock_n_oe);
  cbsrl_mem_model u_mem (.clk, .rstn, .address_latch_strobe, .cyc_done, .waits(pm_waits),
    .mode(pm_mode), .async_ready_in, .sync_ready_in);

  // strap tied to ground wins over the weak pull-up
  assign read_strobe_n_in = strap_gnd ? 1'h0 : (read_strobe_n_oe ? read_strobe_n_out
                                                : read_strobe_pullup_en);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ==================================================================
  // shared tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic do_reset(input logic gnd);
    rstn = 1'h0;
    strap_gnd = gnd;
    repeat (10) tick();
    rstn = 1'h1;
    repeat (8) tick();
    chk("strap_done", 8'h1, {7'h0, stat.strap_done});
    chk("qs_mode", {7'h0, gnd}, {7'h0, stat.qs_mode});
    chk("pins_float", {6'h0, ~gnd, 1'h0}, {6'h0, read_strobe_n_oe, lock_n_oe});
  endtask : do_reset
  // one bus cycle; sampled late in each cycle, after the mid-cycle strobe edge
  task automatic run_cyc(input cbsrl_kind_t k, input logic [3:0] w, input logic [1:0] m,
                         input logic [3:0] exp_w);
    logic [7:0] nw, lo, st, e;
    int n;
    nw = 8'h0;
    lo = 8'h0;
    st = 8'h0;
    n = 0;
    e = {4'h0, exp_w} + 8'h2;
    pm_waits = w;
    pm_mode = m;
    cyc_req = '{1'h1, k};
    #6;
    while (!cyc_req_ready && n < 50) begin
      @(posedge clk);
      #7;
      n++;
    end
    tick();
    cyc_req.valid = 1'h0;
    #6;
    while (cyc_done !== 1'h1 && n < 50) begin
      nw += {7'h0, stat.t_state === CBSRL_TW};
      lo += {7'h0, read_strobe_n_oe && !read_strobe_n_out};
      st += {7'h0, !store_strobe_n};
      @(posedge clk);
      #7;
      n++;
    end
    chk("done", 8'h1, {7'h0, cyc_done});
    chk("waits", {4'h0, exp_w}, nw);
    chk("read_low", (k == CBSRL_KIND_WRITE) ? 8'h0 : e, lo);
    chk("store_low", (k == CBSRL_KIND_WRITE) ? e : 8'h0, st);
    tick();
  endtask : run_cyc
  // ==================================================================
  // scenarios
  task automatic t_lock();
    lock_prefix = 1'h1;
    tick();
    lock_prefix = 1'h0;
    run_cyc(CBSRL_KIND_READ, 4'h0, 2'h0, 4'h0);
    chk("lock_on", 8'h2, {6'h0, lock_n_oe, lock_n_out});
    cyc_req = '{1'h1, CBSRL_KIND_FETCH};
    repeat (3) begin
      #6;
      chk("fetch_refused", 8'h0, {7'h0, cyc_req_ready});
      tick();
    end
    cyc_req.valid = 1'h0;
    chk("lock_held", 8'h2, {6'h0, lock_n_oe, lock_n_out});
    instr_done = 1'h1;
    tick();
    instr_done = 1'h0;
    repeat (2) tick();
    chk("lock_off", 8'h0, {7'h0, lock_n_oe});
    run_cyc(CBSRL_KIND_FETCH, 4'h0, 2'h0, 4'h0);
  endtask : t_lock
  task automatic t_hold();
    hold_float = 1'h1;
    cyc_req = '{1'h1, CBSRL_KIND_READ};
    repeat (2) tick();
    #6;
    chk("hold", 8'h0, {6'h0, read_strobe_n_oe, cyc_req_ready});
    tick();
    hold_float = 1'h0;
    cyc_req.valid = 1'h0;
    run_cyc(CBSRL_KIND_READ, 4'h1, 2'h0, 4'h1);
  endtask : t_hold
  task automatic t_queue();
    do_reset(1'h1);
    for (int q = 0; q < 4; q++) begin
      queue_code = q[1:0];
      repeat (2) tick();
      chk("queue_pins", {6'h0, q[1:0]}, {6'h0, store_strobe_n, address_latch_strobe});
      chk("strobe_float", 8'h0, {7'h0, read_strobe_n_oe});
    end
  endtask : t_queue
  task automatic close_out();
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // ==================================================================
  // main sequence and watchdog
  initial begin
    {rstn, hold_float, lock_prefix, instr_done, strap_gnd} = 5'h0;
    cyc_req = '0;
    queue_code = 2'h0;
    pm_waits = 4'h0;
    pm_mode = 2'h0;
    fails = 0;
    comparisons = 0;
    do_reset(1'h0);
    for (int w = 0; w < 4; w++) begin
      run_cyc(CBSRL_KIND_READ, w[3:0], 2'h0, w[3:0]);
      run_cyc(CBSRL_KIND_WRITE, w[3:0], 2'h0, w[3:0]);
    end
    run_cyc(CBSRL_KIND_READ, 4'h1, 2'h1, 4'h3);
    run_cyc(CBSRL_KIND_READ, 4'h3, 2'h2, 4'h0);
    t_lock();
    t_hold();
    t_queue();
    close_out();
  end
  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule : tb_top
